// file: rtl/usart_sync_slave_port.sv
// synchronous slave half-duplex serial port with register port and interrupt logic
// What this block does
// - transmit status and control register at 0x98 with all listed fields
// - shift clock comes only from the external clock pin, never driven
// - clock source bit 7 cleared selects slave operation
// - transfers continue while the core sleeps
// - first written word moves at once into the shift register and shifts
// - second word waits in holding register, buffer free flag stays clear
// - after first word leaves, held word moves in and buffer free sets
// - enabled buffer free flag wakes core; with global enable vector 0x0004
// - single receive enable ignored; only continuous receive enable counts
// - word received during sleep moves into the receive holding register
// - reception sets receive done flag; enabled it interrupts and wakes
// - clearing continuous receive enable clears the overrun flag; the receive error interrupt flag stays set
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

module usart_sync_slave_port #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_nrst,
    input  wire usart_sync_slave_pkg::reg_addr_t i_addr,
    input  wire usart_sync_slave_pkg::reg_data_t i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    input  wire logic                          i_core_sleep,
    input  wire logic                          i_global_irq_enable,
    input  wire logic                          i_shift_clk,
    input  wire logic                          i_data,
    output usart_sync_slave_pkg::reg_data_t      o_rdata,
    output logic                               o_data,
    output logic                               o_data_oe_n,
    output logic                               o_shift_clk,
    output logic                               o_shift_clk_oe_n,
    output logic                               o_irq,
    output logic                               o_wake,
    output logic                               o_vector_req,
    output logic [15:0]                        o_vector_addr
);
    import usart_sync_slave_pkg::*;

    // the synchroniser needs at least two stages
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    tx_ctl_t                tx_ctl;
    rx_ctl_t                rx_ctl;
    link_state_t            state;
    logic [SYNC_STAGES-1:0] clk_sync;
    logic [SYNC_STAGES-1:0] data_sync;
    logic                   clk_prev;
    logic                   clk_fall;
    logic                   data_in;
    logic [3:0]             bit_cnt;
    logic [3:0]             last_tx;
    logic [3:0]             last_rx;
    logic [3:0]             last_bit;
    logic [8:0]             tx_shift;
    logic [7:0]             tx_hold;
    logic                   tx_hold_ninth;
    logic                   tx_hold_full;
    logic [8:0]             rx_shift;
    logic [8:0]             rx_word;
    logic [7:0]             rx_hold;
    logic                   rx_hold_ninth;
    logic                   rx_hold_full;
    logic                   overrun;
    logic [IRQ_W-1:0]       irq_status;
    logic [IRQ_W-1:0]       irq_mask;
    logic [IRQ_W-1:0]       irq_set;
    logic [IRQ_W-1:0]       irq_w1c;
    logic [IRQ_W-1:0]       irq_hw_clr;
    logic                   slave_cfg;
    logic                   tx_on;
    logic                   rx_on;
    logic                   wr_txhold;
    logic                   tx_accept;
    logic                   rd_rxhold;
    logic                   tx_end;
    logic                   tx_move;
    logic                   rx_done;
    logic                   rx_store;
    logic                   shift_empty;
    reg_data_t              tx_ctl_rd;
    reg_data_t              rx_ctl_rd;

    // pin synchronisers; only the last stage feeds any logic
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_sync  <= '0;
            data_sync <= '1;
            clk_prev  <= 1'b0;
        end else begin
            clk_sync  <= {clk_sync[SYNC_STAGES-2:0], i_shift_clk};
            data_sync <= {data_sync[SYNC_STAGES-2:0], i_data};
            clk_prev  <= clk_sync[SYNC_STAGES-1];
        end
    end

    // falling edge of the external shift clock is the bit strobe
    assign clk_fall = clk_prev & ~clk_sync[SYNC_STAGES-1];
    assign data_in  = data_sync[SYNC_STAGES-1];

    // mode decode; sleep plays no part, so shifting goes on during sleep
    assign slave_cfg = rx_ctl.serial_port_enable & tx_ctl.sync_mode_select
                     & ~tx_ctl.clock_source_select;
    assign rx_on     = slave_cfg & rx_ctl.continuous_receive_enable;
    assign tx_on     = slave_cfg & tx_ctl.transmit_enable_bit & ~rx_ctl.continuous_receive_enable;
    assign last_tx   = tx_ctl.nine_bit_transmit_select ? LAST_BIT_9 : LAST_BIT_8;
    assign last_rx   = rx_ctl.nine_bit_receive_select ? LAST_BIT_9 : LAST_BIT_8;
    assign last_bit  = (state == LINK_RX) ? last_rx : last_tx;

    // bus strobes
    assign wr_txhold = i_wr && (i_addr == TXHOLD_ADDR);
    assign rd_rxhold = i_rd && (i_addr == RXHOLD_ADDR);
    assign irq_w1c   = (i_wr && (i_addr == IRQ_STATUS_ADDR)) ? i_wdata[IRQ_W-1:0] : IRQ_NONE;

    // transmit hand-off from holding to shift register
    assign tx_end    = (state == LINK_TX) && clk_fall && (bit_cnt == last_tx);
    assign tx_move   = tx_on && tx_hold_full && ((state == LINK_IDLE) || tx_end);
    assign tx_accept = wr_txhold && (!tx_hold_full || tx_move);
    assign shift_empty = (state != LINK_TX);

    // receive completion
    assign rx_done  = (state == LINK_RX) && clk_fall && (bit_cnt == last_rx);
    assign rx_store = rx_done && (!rx_hold_full || rd_rxhold);

    // last incoming bit joins the word in the same cycle it is sampled
    always_comb begin
        rx_word          = rx_shift;
        rx_word[bit_cnt] = data_in;
    end

    // link state machine
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= LINK_IDLE;
        end else begin
            case (state)
                LINK_IDLE: begin
                    if (rx_on) begin
                        state <= LINK_RX;
                    end else if (tx_move) begin
                        state <= LINK_TX;
                    end
                end
                LINK_TX: begin
                    if (!tx_on) begin
                        state <= LINK_IDLE;
                    end else if (tx_end && !tx_move) begin
                        state <= LINK_IDLE;
                    end
                end
                LINK_RX: begin
                    if (!rx_on) begin
                        state <= LINK_IDLE;
                    end
                end
                default: begin
                    state <= LINK_IDLE;
                end
            endcase
        end
    end

    // bit counter, shared by both directions since the link is half duplex
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_cnt <= BIT_ZERO;
        end else if (tx_move || (state == LINK_IDLE)) begin
            bit_cnt <= BIT_ZERO;
        end else if (clk_fall) begin
            bit_cnt <= (bit_cnt == last_bit) ? BIT_ZERO : bit_cnt + BIT_STEP;
        end
    end

    // transmit holding register; a write while it is occupied is dropped unless the held word moves out in that cycle
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_hold       <= '0;
            tx_hold_ninth <= 1'b0;
            tx_hold_full  <= 1'b0;
        end else if (tx_accept) begin
            tx_hold       <= i_wdata;
            tx_hold_ninth <= tx_ctl.transmit_ninth_bit;
            tx_hold_full  <= 1'b1;
        end else if (tx_move) begin
            tx_hold_full  <= 1'b0;
        end
    end

    // transmit shift register, bit 0 is on the line
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_shift <= TX_IDLE_LINE;
        end else if (tx_move) begin
            tx_shift <= {tx_hold_ninth, tx_hold};
        end else if ((state == LINK_TX) && clk_fall) begin
            tx_shift <= {1'b1, tx_shift[8:1]};
        end
    end

    // data pin driven while transmit is enabled in slave mode and continuous receive is off; clock pin is never driven
    assign o_data           = tx_shift[0];
    assign o_data_oe_n      = ~tx_on;
    assign o_shift_clk      = 1'b0;
    assign o_shift_clk_oe_n = 1'b1;

    // receive shift and holding registers
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_shift      <= RX_CLEAR;
            rx_hold       <= '0;
            rx_hold_ninth <= 1'b0;
            rx_hold_full  <= 1'b0;
        end else begin
            if ((state == LINK_RX) && clk_fall) begin
                rx_shift[bit_cnt] <= data_in;
            end
            if (rx_store) begin
                rx_hold       <= rx_word[7:0];
                rx_hold_ninth <= rx_ctl.nine_bit_receive_select & rx_word[8];
                rx_hold_full  <= 1'b1;
            end else if (rd_rxhold) begin
                rx_hold_full  <= 1'b0;
            end
        end
    end

    // overrun: word lost because the holding register was unread
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            overrun <= 1'b0;
        end else if (!rx_ctl.continuous_receive_enable) begin
            overrun <= 1'b0;
        end else if (rx_done && !rx_store) begin
            overrun <= 1'b1;
        end
    end

    // sticky events; a set in the clearing cycle wins
    assign irq_set[IRQ_TX_FREE]    = tx_move && !wr_txhold;
    assign irq_set[IRQ_RX_DONE]    = rx_store;
    assign irq_set[IRQ_RX_ERR]     = rx_done && !rx_store;
    assign irq_hw_clr[IRQ_TX_FREE] = tx_accept;
    assign irq_hw_clr[IRQ_RX_DONE] = 1'b0;
    assign irq_hw_clr[IRQ_RX_ERR]  = 1'b0;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_status <= IRQ_NONE;
        end else begin
            irq_status <= (irq_status & ~irq_w1c & ~irq_hw_clr) | irq_set;
        end
    end

    // interrupt, wake and vector request
    assign o_irq         = |(irq_status & irq_mask);
    assign o_wake        = o_irq & i_core_sleep;
    assign o_vector_req  = o_irq & i_global_irq_enable;
    assign o_vector_addr = IRQ_VECTOR;

    // control register writes; read-only and unused bits are masked off
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_ctl   <= tx_ctl_t'(TX_CTL_RESET);
            rx_ctl   <= rx_ctl_t'(RX_CTL_RESET);
            irq_mask <= IRQ_NONE;
        end else if (i_wr) begin
            if (i_addr == TX_CTL_ADDR) begin
                tx_ctl <= tx_ctl_t'(i_wdata & TX_CTL_WMASK);
            end else if (i_addr == RX_CTL_ADDR) begin
                rx_ctl <= rx_ctl_t'(i_wdata & RX_CTL_WMASK);
            end else if (i_addr == IRQ_MASK_ADDR) begin
                irq_mask <= i_wdata[IRQ_W-1:0];
            end
        end
    end

    // read images with live status fields
    assign tx_ctl_rd = {tx_ctl.clock_source_select, tx_ctl.nine_bit_transmit_select,
                        tx_ctl.transmit_enable_bit, tx_ctl.sync_mode_select, 1'b0,
                        tx_ctl.high_speed_rate_select, shift_empty, tx_ctl.transmit_ninth_bit};
    assign rx_ctl_rd = {rx_ctl.serial_port_enable, rx_ctl.nine_bit_receive_select,
                        rx_ctl.single_receive_enable, rx_ctl.continuous_receive_enable,
                        2'b00, overrun, rx_hold_ninth};

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= RDATA_IDLE;
        end else if (!i_rd) begin
            o_rdata <= RDATA_IDLE;
        end else if (i_addr == TX_CTL_ADDR) begin
            o_rdata <= tx_ctl_rd;
        end else if (i_addr == RX_CTL_ADDR) begin
            o_rdata <= rx_ctl_rd;
        end else if (i_addr == RXHOLD_ADDR) begin
            o_rdata <= rx_hold;
        end else if (i_addr == IRQ_STATUS_ADDR) begin
            o_rdata <= {5'h00, irq_status};
        end else if (i_addr == IRQ_MASK_ADDR) begin
            o_rdata <= {5'h00, irq_mask};
        end else begin
            o_rdata <= RDATA_IDLE;
        end
    end

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    property p_tx_ctl_read;
        i_rd && (i_addr == TX_CTL_ADDR) |=> o_rdata == $past(tx_ctl_rd);
    endproperty
    a_tx_ctl_read: assert property (p_tx_ctl_read) else $error("status register read mismatch");

    property p_clk_not_driven;
        o_shift_clk_oe_n;
    endproperty
    a_clk_not_driven: assert property (p_clk_not_driven) else $error("shift clock pin driven");

    property p_master_no_tx;
        (state == LINK_IDLE) && tx_ctl.clock_source_select |=> state == LINK_IDLE;
    endproperty
    a_master_no_tx: assert property (p_master_no_tx) else $error("shifting outside slave mode");

    property p_first_moves;
        (state == LINK_IDLE) && !rx_on && tx_on && tx_hold_full && !wr_txhold
            |=> (state == LINK_TX) && !tx_hold_full && (tx_shift[7:0] == $past(tx_hold));
    endproperty
    a_first_moves: assert property (p_first_moves) else $error("first word not loaded");

    property p_flag_clear_held;
        tx_hold_full |-> !irq_status[IRQ_TX_FREE];
    endproperty
    a_flag_clear_held: assert property (p_flag_clear_held) else $error("buffer free set while occupied");

    property p_chain_reload;
        tx_end && tx_on && tx_hold_full && !wr_txhold
            |=> irq_status[IRQ_TX_FREE] && (state == LINK_TX) && (bit_cnt == BIT_ZERO);
    endproperty
    a_chain_reload: assert property (p_chain_reload) else $error("held word not chained");

    property p_wake;
        irq_status[IRQ_TX_FREE] && irq_mask[IRQ_TX_FREE] && i_core_sleep |-> o_wake && o_irq;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on buffer free");

    property p_single_ignored;
        !rx_ctl.continuous_receive_enable |=> state != LINK_RX;
    endproperty
    a_single_ignored: assert property (p_single_ignored) else $error("receiving without continuous enable");

    property p_rx_done;
        rx_store |=> irq_status[IRQ_RX_DONE] && rx_hold_full && (rx_hold == $past(rx_word[7:0]));
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("received word not stored");

    property p_err_clear;
        !rx_ctl.continuous_receive_enable |=> !overrun;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error kept after receive disable");

    property p_lsb_first;
        (state == LINK_TX) && clk_fall && !tx_end |=> o_data == $past(tx_shift[1]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong");

    property p_empty_flag;
        tx_ctl_rd[1] == (state != LINK_TX);
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("shift empty flag wrong");

    c_chain: cover property (tx_end && tx_move);
    c_rx_word: cover property (rx_store && i_core_sleep);
    c_overrun: cover property (rx_done && !rx_store);

endmodule

// file: rtl/usart_sync_slave_pkg.sv
// constants, register layouts and state encodings for the synchronous slave serial port
package usart_sync_slave_pkg;

    typedef logic [7:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;

    // register map
    localparam reg_addr_t TX_CTL_ADDR     = 8'h98;
    localparam reg_addr_t RX_CTL_ADDR     = 8'h18;
    localparam reg_addr_t TXHOLD_ADDR     = 8'h19;
    localparam reg_addr_t RXHOLD_ADDR     = 8'h1A;
    localparam reg_addr_t IRQ_STATUS_ADDR = 8'h0C;
    localparam reg_addr_t IRQ_MASK_ADDR   = 8'h8C;

    // reset values and writable-bit masks
    localparam reg_data_t TX_CTL_RESET = 8'h02;
    localparam reg_data_t RX_CTL_RESET = 8'h00;
    localparam reg_data_t TX_CTL_WMASK = 8'hF5;
    localparam reg_data_t RX_CTL_WMASK = 8'hF0;
    localparam reg_data_t RDATA_IDLE   = 8'h00;

    // core interrupt vector
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

    // interrupt status and mask bit positions
    localparam int IRQ_TX_FREE = 0;
    localparam int IRQ_RX_DONE = 1;
    localparam int IRQ_RX_ERR  = 2;
    localparam int IRQ_W       = 3;
    localparam logic [IRQ_W-1:0] IRQ_NONE = 3'h0;

    // index of the last bit of a word
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [3:0] BIT_ZERO   = 4'h0;
    localparam logic [3:0] BIT_STEP   = 4'h1;

    // idle level of the transmit line and shift register
    localparam logic [8:0] TX_IDLE_LINE = 9'h1FF;
    localparam logic [8:0] RX_CLEAR     = 9'h000;

    // transmit status and control register image
    typedef struct packed {
        logic clock_source_select;
        logic nine_bit_transmit_select;
        logic transmit_enable_bit;
        logic sync_mode_select;
        logic unused3;
        logic high_speed_rate_select;
        logic shift_reg_empty_flag;
        logic transmit_ninth_bit;
    } tx_ctl_t;

    // receive status and control register image
    typedef struct packed {
        logic serial_port_enable;
        logic nine_bit_receive_select;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic unused3;
        logic unused2;
        logic overrun_error;
        logic receive_ninth_bit;
    } rx_ctl_t;

    // link state, gray coded along idle -> transmit -> receive
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_TX   = 2'b01,
        LINK_RX   = 2'b11
    } link_state_t;

endpackage

// file: testbench/sync_master_model.sv
// external synchronous master: makes the shift clock and swaps one word with the slave
`timescale 1ns/1ps

module sync_master_model (
    input  wire logic i_sdata,
    output logic      o_sclk,
    output logic      o_sdata
);
    // clock rests low between frames; the data line then shows the inverse of its last bit
    initial begin
        o_sclk  = 1'b0;
        o_sdata = 1'b1;
    end

    // one frame, 800 ns per bit, lsb first; the slave strobes on the falling edge
    task automatic xfer(input logic [8:0] w, input int n, output logic [8:0] r);
        r = 9'h000;
        #37;
        for (int i = 0; i < n; i++) begin
            o_sdata = w[i];
            o_sclk  = 1'b1;
            #380;
            r[i]    = i_sdata;
            #20;
            o_sclk  = 1'b0;
            #400;
        end
        o_sdata = ~o_sdata;
    endtask
endmodule

// file: testbench/usart_sync_slave_port_tb_top.sv
// testbench for the synchronous slave serial port: register access, sleep transmit and receive
`timescale 1ns/1ps

module usart_sync_slave_port_tb_top;
    import usart_sync_slave_pkg::*;

    logic        i_core_clk = 1'b0;
    logic        i_nrst = 1'b0;
    reg_addr_t   i_addr = 8'h00;
    reg_data_t   i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_core_sleep = 1'b0;
    logic        i_global_irq_enable = 1'b0;
    logic        sclk;
    logic        m_data;
    logic        data_wire;
    reg_data_t   o_rdata;
    logic        o_data;
    logic        o_data_oe_n;
    logic        o_shift_clk;
    logic        o_shift_clk_oe_n;
    logic        o_irq;
    logic        o_wake;
    logic        o_vector_req;
    logic [15:0] o_vector_addr;
    logic [8:0]  rw;
    reg_data_t   rd;
    int          err_total = 0;
    int          checks_done = 0;

    // 10 MHz core clock
    always #50 i_core_clk = ~i_core_clk;

    // shared data wire: the slave wins while its enable is low
    assign data_wire = !o_data_oe_n ? o_data : m_data;

    usart_sync_slave_port i_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_core_sleep(i_core_sleep), .i_global_irq_enable(i_global_irq_enable),
        .i_shift_clk(sclk), .i_data(data_wire), .o_rdata(o_rdata), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
        .o_shift_clk(o_shift_clk), .o_shift_clk_oe_n(o_shift_clk_oe_n), .o_irq(o_irq), .o_wake(o_wake),
        .o_vector_req(o_vector_req), .o_vector_addr(o_vector_addr));

    sync_master_model i_master (.i_sdata(data_wire), .o_sclk(sclk), .o_sdata(m_data));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bus cycles: one strobe cycle, read data taken in the following cycle only
    task automatic bus_write(input reg_addr_t a, input reg_data_t d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic bus_read(input reg_addr_t a, output reg_data_t d);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic read_check(input string name, input reg_addr_t a, input reg_data_t exp);
        reg_data_t v;
        bus_read(a, v);
        check(name, {8'h00, v}, {8'h00, exp});
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // reset values, read-only bits, unmapped place, clock pin never driven
    task automatic test_regs();
        read_check("tx_ctl_rst", TX_CTL_ADDR, 8'h02);
        read_check("rx_ctl_rst", RX_CTL_ADDR, 8'h00);
        bus_write(8'h55, 8'hFF);
        read_check("unmapped", 8'h55, 8'h00);
        check("clk_oe_n", {15'h0000, o_shift_clk_oe_n}, 16'h0001);
        check("clk_out", {15'h0000, o_shift_clk}, 16'h0000);
        bus_write(TX_CTL_ADDR, 8'hFF);
        read_check("tx_ctl_rw", TX_CTL_ADDR, 8'hF7);
        bus_write(TX_CTL_ADDR, 8'h00);
    endtask

    // two words while asleep: first shifts, second waits, flag rises on the reload
    task automatic test_tx();
        bus_write(IRQ_MASK_ADDR, 8'h01);
        bus_write(RX_CTL_ADDR, 8'h80);
        bus_write(TX_CTL_ADDR, 8'h30);
        #1;
        check("oe_slave", {15'h0000, o_data_oe_n}, 16'h0000);
        i_core_sleep <= 1'b1;
        bus_write(TXHOLD_ADDR, 8'hA5);
        repeat (3) @(posedge i_core_clk);
        bus_write(IRQ_STATUS_ADDR, 8'h01);
        bus_write(TXHOLD_ADDR, 8'h3C);
        read_check("free_clear", IRQ_STATUS_ADDR, 8'h00);
        read_check("shift_reg_empty_flag_busy", TX_CTL_ADDR, 8'h30);
        check("no_wake", {15'h0000, o_wake}, 16'h0000);
        i_master.xfer(9'h000, 8, rw);
        check("word1", {7'h00, rw}, 16'h00A5);
        repeat (6) @(posedge i_core_clk);
        check("wake", {15'h0000, o_wake}, 16'h0001);
        check("irq_tx", {15'h0000, o_irq}, 16'h0001);
        check("vec_off", {15'h0000, o_vector_req}, 16'h0000);
        i_global_irq_enable <= 1'b1;
        @(posedge i_core_clk);
        #1;
        check("vec_on", {15'h0000, o_vector_req}, 16'h0001);
        check("vec_addr", o_vector_addr, 16'h0004);
        read_check("free_set", IRQ_STATUS_ADDR, 8'h01);
        i_master.xfer(9'h000, 8, rw);
        check("word2", {7'h00, rw}, 16'h003C);
        repeat (6) @(posedge i_core_clk);
        read_check("shift_reg_empty_flag_idle", TX_CTL_ADDR, 8'h32);
        bus_write(TX_CTL_ADDR, 8'h71);
        bus_write(TXHOLD_ADDR, 8'h5A);
        repeat (3) @(posedge i_core_clk);
        i_master.xfer(9'h000, 9, rw);
        check("word9", {7'h00, rw}, 16'h015A);
        repeat (6) @(posedge i_core_clk);
        bus_write(TX_CTL_ADDR, 8'h10);
        bus_write(IRQ_STATUS_ADDR, 8'h07);
    endtask

    // reception asleep, single enable ignored, overrun and its clearing
    task automatic test_rx();
        bus_write(IRQ_MASK_ADDR, 8'h02);
        bus_write(RX_CTL_ADDR, 8'hA0);
        i_master.xfer(9'h0F0, 8, rw);
        repeat (6) @(posedge i_core_clk);
        read_check("single_ign", IRQ_STATUS_ADDR, 8'h00);
        bus_write(RX_CTL_ADDR, 8'hD0);
        i_master.xfer(9'h1C3, 9, rw);
        repeat (6) @(posedge i_core_clk);
        check("rx_wake", {15'h0000, o_wake}, 16'h0001);
        check("irq_rx", {15'h0000, o_irq}, 16'h0001);
        read_check("rx_status", IRQ_STATUS_ADDR, 8'h02);
        read_check("rx_ninth", RX_CTL_ADDR, 8'hD1);
        read_check("rx_byte", RXHOLD_ADDR, 8'hC3);
        bus_write(IRQ_STATUS_ADDR, 8'h07);
        i_master.xfer(9'h0AA, 9, rw);
        i_master.xfer(9'h055, 9, rw);
        repeat (6) @(posedge i_core_clk);
        read_check("ovr_status", IRQ_STATUS_ADDR, 8'h06);
        read_check("ovr_flag", RX_CTL_ADDR, 8'hD2);
        bus_write(RX_CTL_ADDR, 8'hC0);
        read_check("ovr_clear", RX_CTL_ADDR, 8'hC0);
        read_check("ovr_kept", RXHOLD_ADDR, 8'hAA);
    endtask

    // main sequence after a six-cycle reset
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        @(posedge i_core_clk);
        test_regs();
        test_tx();
        test_rx();
        complete_run();
    end

    // watchdog well beyond the ~48 us the frames need
    initial begin
        #2_000_000;
        err_total++;
        complete_run();
    end
endmodule
